// [core/wd_counters_pkg.sv]
package wd_counters_pkg;
  // ----------------------------------------
  // Counter widths and limits
  // ----------------------------------------
  localparam int TALLY_W = 3;
  localparam logic [2:0] FAULT_RESET = 3'h6;
  localparam logic [2:0] FAULT_ALARM_LIMIT = 3'h4;
  localparam logic [2:0] FAULT_MAX = 3'h7;
  localparam logic [2:0] FAULT_ZERO = 3'h0;
  localparam logic [2:0] TALLY_MAX = 3'h7;
  localparam logic [2:0] TALLY_ZERO = 3'h0;
  localparam logic [2:0] TALLY_STEP = 3'h1;
  // ----------------------------------------
  // Answer byte index
  // ----------------------------------------
  localparam logic [1:0] INDEX_FIRST = 2'h3;
  localparam logic [1:0] INDEX_LAST = 2'h0;
  localparam logic [1:0] INDEX_STEP = 2'h1;
  // ----------------------------------------
  // Reset request pulse length
  // ----------------------------------------
  localparam int RESET_HOLD_NS = 320;
  localparam int CLOCK_NS = 20;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam logic [4:0] RESET_HOLD = 5'(RESET_HOLD_CYCLES);
endpackage

// [core/answer_checker.sv]
`timescale 1ns/1ps
module answer_checker (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  // Answer stream
  input wire logic i_write,
  input wire logic [7:0] i_data,
  input wire logic [3:0] i_question,
  input wire logic i_seq_run,
  // Status
  output logic [1:0] o_index,
  output logic o_mismatch,
  output logic o_launch,
  output logic o_answer_wrong
);
  logic [7:0] expected;
  logic byte_bad;

  // ----------------------------------------
  // Expected byte
  // ----------------------------------------
  always_comb begin
    expected[7] = i_question[2] ^ o_index[0];
    expected[6] = i_question[0] ^ o_index[0];
    expected[5] = i_question[3] ^ o_index[0];
    expected[4] = i_question[1] ^ o_index[0];
    expected[3] = i_question[2] ^ i_question[0] ^ i_question[3] ^ o_index[1];
    expected[2] = i_question[0] ^ i_question[3] ^ i_question[1] ^ o_index[1];
    expected[1] = i_question[2] ^ i_question[0] ^ i_question[1] ^ o_index[1];
    expected[0] = o_index[1] ^ i_question[3] ^ i_question[0];
  end

  assign byte_bad = i_write && (i_data != expected);
  assign o_launch = i_write && (o_index == wd_counters_pkg::INDEX_LAST);
  assign o_answer_wrong = o_mismatch || byte_bad;

  // ----------------------------------------
  // Index and mismatch flag
  // ----------------------------------------
  // index steps down per byte
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_index <= wd_counters_pkg::INDEX_FIRST;
    end else if (i_enable) begin
      if (i_seq_run || o_launch) begin
        o_index <= wd_counters_pkg::INDEX_FIRST;
      end else if (i_write) begin
        o_index <= o_index - wd_counters_pkg::INDEX_STEP;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_mismatch <= 1'b0;
    end else if (i_enable) begin
      if (i_seq_run || o_launch) begin
        o_mismatch <= 1'b0;
      end else if (byte_bad) begin
        o_mismatch <= 1'b1;
      end
    end
  end
endmodule

// [core/qa_watchdog_counters.sv]
`timescale 1ns/1ps
module qa_watchdog_counters (
  // Clock, undervoltage reset, enable
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  // Answer byte writes and question
  input wire logic i_answer_write,
  input wire logic [7:0] i_answer_data,
  input wire logic [3:0] i_question_value,
  // Timing verdict and other runs
  input wire logic i_timing_ok,
  input wire logic i_error_run,
  // Configuration and events
  input wire logic i_watchdog_reset_enable,
  input wire logic i_soft_reset,
  input wire logic i_power_latch,
  input wire logic i_test_mode,
  input wire logic i_occurred_read,
  // Alarm pin, open drain
  input wire logic i_alarm_pin_n,
  output logic o_alarm_pin_n,
  output logic o_alarm_pin_oe,
  // Counter state
  output logic [2:0] o_fault_tally,
  output logic o_alarm_internal_flag,
  output logic [2:0] o_shutdown_tally,
  output logic [2:0] o_reset_tally,
  output logic [1:0] o_answer_byte_index,
  output logic o_answer_mismatch,
  // Reactions
  output logic o_latch_shutdown,
  output logic o_relay_off,
  output logic o_power_stage_inhibit,
  output logic o_watchdog_reset_request,
  output logic o_reset_pin_oe,
  output logic o_watchdog_reset_occurred,
  output logic o_cycle_launch
);
  logic [2:0] fault_tally;
  logic [2:0] next_fault_tally;
  logic [4:0] hold_count;
  logic pin_meta;
  logic pin_sync;
  logic launch;
  logic answer_wrong;
  logic seq_run;
  logic run_error;
  logic overflow;
  logic reset_fire;
  logic next_alarm;

  // ----------------------------------------
  // Answer comparison
  // ----------------------------------------
  answer_checker u_checker (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_enable(i_enable),
    .i_write(i_answer_write),
    .i_data(i_answer_data),
    .i_question(i_question_value),
    .i_seq_run(i_error_run),
    .o_index(o_answer_byte_index),
    .o_mismatch(o_answer_mismatch),
    .o_launch(launch),
    .o_answer_wrong(answer_wrong)
  );

  // ----------------------------------------
  // Sequencer run verdict
  // ----------------------------------------
  // Runs not started by an answer always count as errors
  assign seq_run = launch || i_error_run;
  // wrong, late or zero-time answer is an error
  assign run_error = i_error_run || answer_wrong || !i_timing_ok;
  assign overflow = seq_run && run_error && (fault_tally == wd_counters_pkg::FAULT_MAX);
  assign reset_fire = overflow && i_watchdog_reset_enable && (o_reset_tally != wd_counters_pkg::TALLY_MAX);

  // ----------------------------------------
  // Fault tally
  // ----------------------------------------
  always_comb begin
    next_fault_tally = fault_tally;
    if (seq_run) begin
      if (overflow) begin
        next_fault_tally = wd_counters_pkg::FAULT_RESET;
      end else if (run_error) begin
        next_fault_tally = fault_tally + wd_counters_pkg::TALLY_STEP;
      end else if (fault_tally != wd_counters_pkg::FAULT_ZERO) begin
        next_fault_tally = fault_tally - wd_counters_pkg::TALLY_STEP;
      end
    end
  end

  assign next_alarm = next_fault_tally > wd_counters_pkg::FAULT_ALARM_LIMIT;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      fault_tally <= wd_counters_pkg::FAULT_RESET;
    end else if (i_enable) begin
      fault_tally <= next_fault_tally;
    end
  end

  assign o_fault_tally = fault_tally;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_alarm_internal_flag <= 1'b1;
    end else if (i_enable) begin
      o_alarm_internal_flag <= next_alarm;
    end
  end

  // ----------------------------------------
  // Alarm pin and power stage inhibit
  // ----------------------------------------
  // Pin level is foreign, so it is synchronised
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else if (i_enable) begin
      pin_meta <= i_alarm_pin_n;
      pin_sync <= pin_meta;
    end
  end

  // test mode forces pin, not flag
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_alarm_pin_oe <= 1'b1;
      o_alarm_pin_n <= 1'b0;
    end else if (i_enable) begin
      o_alarm_pin_oe <= next_alarm || i_test_mode;
      o_alarm_pin_n <= 1'b0;
    end
  end

  // pin in test mode spares stages
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_power_stage_inhibit <= 1'b1;
    end else if (i_enable) begin
      o_power_stage_inhibit <= next_alarm || (!pin_sync && !i_test_mode);
    end
  end

  // ----------------------------------------
  // Shutdown tally and latch shutdown
  // ----------------------------------------
  // cleared while alarm is low
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_shutdown_tally <= wd_counters_pkg::TALLY_ZERO;
    end else if (i_enable) begin
      if (!o_alarm_internal_flag) begin
        o_shutdown_tally <= wd_counters_pkg::TALLY_ZERO;
      end else if ((o_shutdown_tally != wd_counters_pkg::TALLY_MAX) && (overflow || i_soft_reset)) begin
        o_shutdown_tally <= o_shutdown_tally + wd_counters_pkg::TALLY_STEP;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_latch_shutdown <= 1'b0;
    end else if (i_enable) begin
      if (!o_alarm_internal_flag) begin
        o_latch_shutdown <= 1'b0;
      end else if ((o_shutdown_tally == wd_counters_pkg::TALLY_MAX)
                   && ((seq_run && run_error) || i_soft_reset)) begin
        o_latch_shutdown <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_relay_off <= 1'b0;
    end else if (i_enable) begin
      o_relay_off <= i_power_latch && o_latch_shutdown;
    end
  end

  // ----------------------------------------
  // Watchdog reset generation
  // ----------------------------------------
  // saturates at seven
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_reset_tally <= wd_counters_pkg::TALLY_ZERO;
    end else if (i_enable) begin
      if (reset_fire) begin
        o_reset_tally <= o_reset_tally + wd_counters_pkg::TALLY_STEP;
      end
    end
  end

  // Pulse held long enough for the reset pin stage
  // enabled overflow fires reset while reset tally is below seven
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      hold_count <= 5'h00;
    end else if (i_enable) begin
      if (!i_watchdog_reset_enable) begin
        hold_count <= 5'h00;
      end else if (reset_fire) begin
        hold_count <= wd_counters_pkg::RESET_HOLD;
      end else if (hold_count != 5'h00) begin
        hold_count <= hold_count - 5'h01;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_watchdog_reset_request <= 1'b0;
      o_reset_pin_oe <= 1'b0;
    end else if (i_enable) begin
      o_watchdog_reset_request <= i_watchdog_reset_enable && (reset_fire || hold_count > 5'h01);
      o_reset_pin_oe <= i_watchdog_reset_enable && (reset_fire || hold_count > 5'h01);
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_watchdog_reset_occurred <= 1'b0;
    end else if (i_enable) begin
      if (reset_fire) begin
        o_watchdog_reset_occurred <= 1'b1;
      end else if (i_occurred_read) begin
        o_watchdog_reset_occurred <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_cycle_launch <= 1'b0;
    end else if (i_enable) begin
      o_cycle_launch <= launch;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_alarm_tracks_tally: assert property (
    o_alarm_internal_flag == (o_fault_tally > 3'h4))
    else $error("alarm flag disagrees with fault tally");

  a_overflow_reload: assert property (
    i_enable && overflow |=> o_fault_tally == 3'h6)
    else $error("fault tally not reloaded after overflow");

  a_good_answer_down: assert property (
    i_enable && launch && !answer_wrong && i_timing_ok && !i_error_run && o_fault_tally != 3'h0
    |=> o_fault_tally == $past(o_fault_tally) - 3'h1)
    else $error("good answer did not lower fault tally");

  a_test_pin_low: assert property (
    i_enable && i_test_mode |=> o_alarm_pin_oe && !o_alarm_pin_n)
    else $error("alarm pin not driven in test mode");

  a_shutdown_cleared: assert property (
    i_enable && !o_alarm_internal_flag |=> o_shutdown_tally == 3'h0)
    else $error("shutdown tally not cleared");

  a_latch_needs_full: assert property (
    $rose(o_latch_shutdown) |-> $past(o_shutdown_tally) == 3'h7)
    else $error("latch shutdown rose below full tally");

  a_relay_follows: assert property (
    i_enable && o_latch_shutdown && i_power_latch |=> o_relay_off)
    else $error("relay not cut in power latch");

  a_reset_disabled: assert property (
    i_enable && !i_watchdog_reset_enable |=> !o_watchdog_reset_request && $stable(o_reset_tally))
    else $error("reset activity while disabled");

  a_reset_fires: assert property (
    i_enable && overflow && i_watchdog_reset_enable && o_reset_tally != 3'h7
    |=> o_watchdog_reset_request && o_reset_tally == $past(o_reset_tally) + 3'h1)
    else $error("enabled overflow did not request reset");

  a_reset_saturated: assert property (
    o_reset_tally == 3'h7 && !o_watchdog_reset_request |=> !$rose(o_watchdog_reset_request))
    else $error("reset requested with full reset tally");

  a_reset_tally_up: assert property (
    o_reset_tally >= $past(o_reset_tally))
    else $error("reset tally went down");

  a_occurred_set: assert property (
    $rose(o_watchdog_reset_request) |-> o_watchdog_reset_occurred)
    else $error("reset occurred flag missing");

  a_index_wrap: assert property (
    i_enable && launch |=> o_answer_byte_index == 2'h3 && !o_answer_mismatch ##0 o_cycle_launch)
    else $error("index did not wrap on last byte");

  c_overflow: cover property (i_enable && overflow);
  c_latch_rise: cover property ($rose(o_latch_shutdown));
  c_reset_pulse: cover property ($rose(o_watchdog_reset_request));
  c_good_answer: cover property (i_enable && launch && !answer_wrong && i_timing_ok);
endmodule

// [sim/host_model.sv]
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic i_clock,
  // Answer byte writes
  output logic o_write,
  output logic [7:0] o_data
);
  // ------
  // Answer bytes
  // ------
  // fixed set per question
  // Table kept apart from the comparator's equations on purpose
  function automatic logic [7:0] reply(input logic [3:0] q, input logic [1:0] idx);
    logic [31:0] w;
    w = 32'h00000000;
    case (q)
      4'h0: w = 32'hff0ff000;
      4'h1: w = 32'hb040bf4f;
      4'h2: w = 32'he919e616;
      4'h3: w = 32'ha656a959;
      4'h4: w = 32'h75857a8a;
      4'h5: w = 32'h3aca35c5;
      4'h6: w = 32'h63936c9c;
      4'h7: w = 32'h2cdc23d3;
      4'h8: w = 32'hd222dd2d;
      4'h9: w = 32'h9d6d9262;
      4'ha: w = 32'hc434cb3b;
      4'hb: w = 32'h8b7b8474;
      4'hc: w = 32'h58a857a7;
      4'hd: w = 32'h17e718e8;
      4'he: w = 32'h4ebe41b1;
      4'hf: w = 32'h01f10efe;
    endcase
    return w[8 * idx +: 8];
  endfunction
  initial begin
    o_write = 1'b0;
    o_data = 8'h00;
  end
  // bytes from index from down to index upto
  // Idle data is inverted so a stale byte never matches by luck
  task automatic send(input logic [3:0] q, input int from, input int upto, input bit bad, input int gap);
    for (int i = from; i >= upto; i--) begin
      if (i < from) begin
        repeat (gap) begin
          @(negedge i_clock);
          o_write = 1'b0;
          o_data = ~o_data;
        end
      end
      @(negedge i_clock);
      o_write = 1'b1;
      o_data = reply(q, 2'(i)) ^ {7'h00, bad};
    end
    @(negedge i_clock);
    o_write = 1'b0;
    o_data = ~o_data;
  endtask
endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  // ------
  // Signals
  // ------
  logic i_clock, i_rst, i_enable, i_timing_ok, i_error_run, i_watchdog_reset_enable;
  logic i_soft_reset, i_power_latch, i_test_mode, i_occurred_read;
  logic [3:0] i_question_value;
  logic answer_write, pin_oe, alarm_flag, mismatch, latch, relay_off, inhibit, request, occurred, launch;
  logic pin_n, rst_pin_oe, ext_pull_n;
  logic [7:0] answer_data;
  logic [2:0] fault, shutdown, rst_tally;
  logic [1:0] index;
  int num_errors = 0;
  int num_checks = 0;
  // Pull-up on the alarm line, ext_pull_n models an outside pull-down
  wire logic alarm_line_n = ~pin_oe & ext_pull_n;

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  host_model host (.i_clock(i_clock), .o_write(answer_write), .o_data(answer_data));

  qa_watchdog_counters dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_enable(i_enable), .i_answer_write(answer_write),
    .i_answer_data(answer_data), .i_question_value(i_question_value), .i_timing_ok(i_timing_ok),
    .i_error_run(i_error_run), .i_watchdog_reset_enable(i_watchdog_reset_enable),
    .i_soft_reset(i_soft_reset), .i_power_latch(i_power_latch), .i_test_mode(i_test_mode),
    .i_occurred_read(i_occurred_read), .i_alarm_pin_n(alarm_line_n), .o_alarm_pin_n(pin_n),
    .o_alarm_pin_oe(pin_oe), .o_fault_tally(fault), .o_alarm_internal_flag(alarm_flag),
    .o_shutdown_tally(shutdown), .o_reset_tally(rst_tally), .o_answer_byte_index(index),
    .o_answer_mismatch(mismatch), .o_latch_shutdown(latch), .o_relay_off(relay_off),
    .o_power_stage_inhibit(inhibit), .o_watchdog_reset_request(request), .o_reset_pin_oe(rst_pin_oe),
    .o_watchdog_reset_occurred(occurred), .o_cycle_launch(launch));

  // ------
  // Helpers
  // ------
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic err_run();
    @(negedge i_clock);
    i_error_run = 1'b1;
    @(negedge i_clock);
    i_error_run = 1'b0;
    cyc(1);
  endtask
  // Steered by the tally so a soft reset side effect cannot skew the count
  task automatic overflow();
    for (int n = 0; n < 8 && fault !== 3'h7; n++) begin
      err_run();
    end
    err_run();
  endtask
  task automatic answer(input logic [3:0] q, input int from, input bit bad, input int gap);
    int n;
    @(negedge i_clock);
    i_question_value = q;
    host.send(q, from, 0, bad, gap);
    n = 0;
    while (launch !== 1'b1 && n < 8) begin
      @(negedge i_clock);
      n++;
    end
    check("launch", 3'h1, 3'(launch));
    cyc(1);
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_reset();
    @(negedge i_clock);
    i_rst = 1'b1;
    cyc(4);
    i_rst = 1'b0;
    cyc(1);
    check("fault", 3'h6, fault);
    check("alarm flag", 3'h1, 3'(alarm_flag));
    check("alarm pin", 3'h1, 3'(pin_oe));
    check("alarm level", 3'h0, 3'(pin_n));
    check("inhibit", 3'h1, 3'(inhibit));
    check("latch", 3'h0, 3'(latch));
    check("request", 3'h0, 3'(request));
    check("shutdown", 3'h0, shutdown);
    check("reset tally", 3'h0, rst_tally);
    check("index", 3'h3, 3'(index));
    check("mismatch", 3'h0, 3'(mismatch));
    $display("done: reset");
  endtask
  task automatic t_good();
    answer(4'h0, 3, 1'b0, 0);
    check("fault", 3'h5, fault);
    answer(4'hb, 3, 1'b0, 2);
    check("fault", 3'h4, fault);
    check("alarm flag", 3'h0, 3'(alarm_flag));
    check("alarm pin", 3'h0, 3'(pin_oe));
    $display("done: good answers");
  endtask
  task automatic t_test_mode();
    i_test_mode = 1'b1;
    cyc(4);
    check("alarm pin", 3'h1, 3'(pin_oe));
    check("alarm flag", 3'h0, 3'(alarm_flag));
    check("inhibit", 3'h0, 3'(inhibit));
    i_test_mode = 1'b0;
    cyc(4);
    check("alarm pin", 3'h0, 3'(pin_oe));
    check("inhibit", 3'h0, 3'(inhibit));
    ext_pull_n = 1'b0;
    cyc(4);
    check("inhibit", 3'h1, 3'(inhibit));
    check("alarm flag", 3'h0, 3'(alarm_flag));
    ext_pull_n = 1'b1;
    i_enable = 1'b0;
    err_run();
    check("fault", 3'h4, fault);
    i_enable = 1'b1;
    cyc(4);
    check("inhibit", 3'h0, 3'(inhibit));
    $display("done: test mode");
  endtask
  task automatic t_wrong();
    i_question_value = 4'h6;
    host.send(4'h6, 3, 1, 1'b1, 0);
    cyc(1);
    check("index", 3'h0, 3'(index));
    check("mismatch", 3'h1, 3'(mismatch));
    answer(4'h6, 0, 1'b0, 0);
    check("fault", 3'h5, fault);
    check("index", 3'h3, 3'(index));
    check("mismatch", 3'h0, 3'(mismatch));
    check("alarm flag", 3'h1, 3'(alarm_flag));
    i_timing_ok = 1'b0;
    answer(4'h9, 3, 1'b0, 1);
    check("fault", 3'h6, fault);
    i_timing_ok = 1'b1;
    $display("done: wrong answers");
  endtask
  task automatic t_shutdown();
    i_soft_reset = 1'b1;
    cyc(1);
    i_soft_reset = 1'b0;
    cyc(1);
    check("shutdown", 3'h1, shutdown);
    overflow();
    check("fault", 3'h6, fault);
    check("shutdown", 3'h2, shutdown);
    check("reset tally", 3'h0, rst_tally);
    check("request", 3'h0, 3'(request));
    $display("done: shutdown tally");
  endtask
  task automatic t_resets();
    i_watchdog_reset_enable = 1'b1;
    i_power_latch = 1'b1;
    for (int k = 1; k <= 8; k++) begin
      overflow();
      check("request", 3'(k < 8), 3'(request));
      check("reset pin", 3'(k < 8), 3'(rst_pin_oe));
      check("reset tally", (k < 7) ? 3'(k) : 3'h7, rst_tally);
      check("occurred", 3'(k < 8), 3'(occurred));
      check("shutdown", (k < 5) ? 3'(k + 2) : 3'h7, shutdown);
      check("latch", 3'(k >= 6), 3'(latch));
      @(negedge i_clock);
      i_occurred_read = 1'b1;
      @(negedge i_clock);
      i_occurred_read = 1'b0;
      cyc(20);
      check("occurred", 3'h0, 3'(occurred));
      check("request", 3'h0, 3'(request));
      check("reset pin", 3'h0, 3'(rst_pin_oe));
      check("relay off", 3'(k >= 6), 3'(relay_off));
    end
    $display("done: watchdog resets");
  endtask
  task automatic t_clear();
    i_watchdog_reset_enable = 1'b0;
    answer(4'h1, 3, 1'b0, 0);
    check("latch", 3'h1, 3'(latch));
    check("shutdown", 3'h7, shutdown);
    answer(4'h2, 3, 1'b0, 0);
    cyc(2);
    check("latch", 3'h0, 3'(latch));
    check("shutdown", 3'h0, shutdown);
    check("relay off", 3'h0, 3'(relay_off));
    check("reset tally", 3'h7, rst_tally);
    $display("done: alarm clear");
  endtask

  // ------
  // Main sequence
  // ------
  initial begin
    i_rst = 1'b1;
    i_enable = 1'b1;
    i_timing_ok = 1'b1;
    i_error_run = 1'b0;
    i_watchdog_reset_enable = 1'b0;
    i_soft_reset = 1'b0;
    i_power_latch = 1'b0;
    i_test_mode = 1'b0;
    i_occurred_read = 1'b0;
    i_question_value = 4'h0;
    ext_pull_n = 1'b1;
    t_reset();
    t_good();
    t_test_mode();
    t_wrong();
    t_shutdown();
    t_resets();
    t_clear();
    t_reset();
    give_verdict();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #200000;
    num_errors++;
    $display("[FAIL] run end expected finish seen hang");
    give_verdict();
  end
endmodule
